// [bus_cond_detect.v]
/*
 finds clock edges and start/stop conditions on the synchronised
 two-wire lines. assumes scl_s and sda_s are already in the clk domain.
*/
`timescale 1ns/1ps
module bus_cond_detect (
   input wire clk,
   input wire sys_rst,
   input wire scl_s,
   input wire sda_s,
   output wire scl_rise,
   output wire scl_fall,
   output wire start_cond,
   output wire stop_cond
);
   reg scl_prev_ff;
   reg sda_prev_ff;

   // idle bus is high on both lines, so reset to that to avoid a false edge
   always @(posedge clk) begin
      if (sys_rst) begin
         scl_prev_ff <= 1'b1;
         sda_prev_ff <= 1'b1;
      end else begin
         scl_prev_ff <= scl_s;
         sda_prev_ff <= sda_s;
      end
   end

   // data moving while the clock stays high marks start or stop
   assign scl_rise = scl_s & ~scl_prev_ff;
   assign scl_fall = ~scl_s & scl_prev_ff;
   assign start_cond = scl_s & scl_prev_ff & sda_prev_ff & ~sda_s; // R22
   assign stop_cond = scl_s & scl_prev_ff & ~sda_prev_ff & sda_s; // R22
endmodule

// [eeprom_front_end_asserts.sv]
/*
 port checker for the two-wire eeprom front end.
 assumes one clk domain and a write cycle of 2**PAGE_AW clocks.
*/
`timescale 1ns/1ps
module eeprom_front_end_asserts #(
   parameter PAGE_AW = 7
) (
   input wire clk,
   input wire sys_rst,
   input wire scl_in,
   input wire sda_in,
   input wire sda_out,
   input wire sda_oe_n,
   input wire standby,
   input wire write_busy
);
   logic [15:0] busy_cnt_ff;
   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);
   // length of the running write cycle, cleared while idle
   always @(posedge clk) begin
      if (sys_rst || !write_busy)
         busy_cnt_ff <= 16'h0000;
      else
         busy_cnt_ff <= busy_cnt_ff + 16'h0001;
   end
   property p_open_drain; sda_out == 1'b0; endproperty
   a_open_drain: assert property (p_open_drain) else $error("data driven high");
   property p_reset; disable iff (1'b0) sys_rst |=> sda_oe_n && standby && !write_busy; endproperty
   a_reset: assert property (p_reset) else $error("active in reset");
   property p_busy_len; $fell(write_busy) |-> busy_cnt_ff == 16'(1 << PAGE_AW); endproperty
   a_busy_len: assert property (p_busy_len) else $error("write cycle length");
   property p_busy_lines; $rose(write_busy) |-> scl_in && sda_in && $past(sda_oe_n); endproperty
   a_busy_lines: assert property (p_busy_lines) else $error("write cycle without stop");
   property p_busy_quiet; write_busy |-> sda_oe_n && !standby; endproperty
   a_busy_quiet: assert property (p_busy_quiet) else $error("busy but active");
   property p_stop; $rose(sda_in) && scl_in && $past(scl_in) |-> ##[1:8] (standby || write_busy);
   endproperty
   a_stop: assert property (p_stop) else $error("stop not decoded");
   property p_drive_edge; $changed(sda_oe_n) |-> !scl_in; endproperty
   a_drive_edge: assert property (p_drive_edge) else $error("data moved in clock high");
   property p_ack_hold; $fell(sda_oe_n) |=> !sda_oe_n [*8]; endproperty
   a_ack_hold: assert property (p_ack_hold) else $error("ack too short");
   property p_standby_rel; standby |-> sda_oe_n; endproperty
   a_standby_rel: assert property (p_standby_rel) else $error("standby but driving");
   c_busy: cover property ($rose(write_busy));
   c_ack: cover property ($fell(sda_oe_n));
   c_standby: cover property ($rose(standby));
endmodule
bind eeprom_slave_front_end eeprom_front_end_asserts #(.PAGE_AW(PAGE_AW)) u_chk (.clk(clk),
   .sys_rst(sys_rst), .scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out),
   .sda_oe_n(sda_oe_n), .standby(standby), .write_busy(write_busy));

// [eeprom_front_map.vh]
/*
 constants for the two-wire eeprom slave front end: select byte layout,
 type identifiers and byte framing. assumes nothing of its surroundings.
*/
`ifndef EEPROM_FRONT_MAP_VH
`define EEPROM_FRONT_MAP_VH

// select byte fields, bit 7 travels first
`define SEL_TYPE_HI 7
`define SEL_TYPE_LO 4
`define SEL_CS_HI 3
`define SEL_CS_LO 1
`define SEL_RW_BIT 0

// type identifiers of the select byte
`define TYPE_ARRAY 4'ha
`define TYPE_IDPAGE 4'hb

// direction bit values
`define DIR_READ 1'b1

// bit periods of one byte before its acknowledge slot
`define BITS_PER_BYTE 4'h8

// reset values
`define ADDR_RESET 16'h0000
`define SHIFT_RESET 8'h00

`endif

// [eeprom_slave_front_end.v]
/*
 two-wire serial eeprom slave: select byte decode, chip select match,
 address bytes, write protect, page buffer with self-timed commit and
 a simple current/sequential read path.
 assumes sys_rst is the power-on reset, scl and sda come from pins and
 the chip select / write protect pads carry pull-downs.
// Summary of operation
// R1: select byte 1010, chip select, direction, msb first
// R2: type 1011 selects the identification page
// R3: select bits 3..1 compared to pins 2..0
// R4: floating chip select pins read as zero
// R5: write protect high blocks all array writes
// R6: floating write protect reads low, writes allowed
// R7: protected: ack select and address, not data
// R8: write bytes acknowledged in ninth bit period
// R9: master acknowledges each read data byte
// R10: write ends ack-stop, read ends nack-stop
// R11: master opens each operation with start, select
// R12: select byte closed by device acknowledge
// R13: storage is 64K or 32K bytes of 8
// R14: ignore bus while power-on reset held
// R15: reset release clears state, enters standby
// R16: reset asserted again stops all responses
// R17: stop enters standby unless write cycle runs
// R18: data line open drain, never driven high
// R19: all bits timed by master serial clock
// R20: first address byte holds bits 15..8
// R21: second address byte holds bits 7..0
// R22: start and stop detected while clock high
// R23: mismatch on chip select: release, go standby
// R24: write cycle only on stop after data ack
// R25: high address byte precedes low address byte
// R26: every byte shifted msb first, one per pulse
*/
`timescale 1ns/1ps
`include "eeprom_front_map.vh"
module eeprom_slave_front_end #(
   parameter MEM_AW = 16,
   parameter PAGE_AW = 7,
   parameter HAS_ID_PAGE = 1
) (
   input wire clk,
   input wire sys_rst,
   input wire scl_in,
   input wire sda_in,
   output wire sda_out,
   output wire sda_oe_n,
   input wire chip_select_pin_0,
   input wire chip_select_pin_1,
   input wire chip_select_pin_2,
   input wire write_protect_input,
   output wire standby,
   output wire write_busy
);
   localparam PAGE = 1 << PAGE_AW;
   localparam [6:0] ST_IDLE = 7'h01;
   localparam [6:0] ST_SEL = 7'h02;
   localparam [6:0] ST_AHI = 7'h04;
   localparam [6:0] ST_ALO = 7'h08;
   localparam [6:0] ST_WDAT = 7'h10;
   localparam [6:0] ST_RDAT = 7'h20;
   localparam [6:0] ST_WCYC = 7'h40;

   wire scl_s;
   wire sda_s;
   wire [2:0] cs_s;
   wire wp_s;
   wire scl_rise;
   wire scl_fall;
   wire start_cond;
   wire stop_cond;

   reg [6:0] state_ff;
   reg [3:0] bit_cnt_ff;
   reg [7:0] shift_ff;
   reg ack_slot_ff;
   reg pull_low_ff;
   reg id_sel_ff;
   reg wp_hold_ff;
   reg data_acked_ff;
   reg master_nack_ff;
   reg [15:0] addr_ff;
   reg [PAGE_AW-1:0] commit_col_ff;
   reg [PAGE-1:0] page_vld_ff;
   reg [7:0] page_buf [0:PAGE-1];
   reg [7:0] mem [0:(1<<MEM_AW)-1];
   reg [7:0] id_mem [0:PAGE-1];

   // pins from outside the clk domain pass two flip-flops
   // the stages clear low while the idle bus is high, so release makes a stray
   // clock fall and then a stray rise; the engine is idle then and ignores both
   sync2 #(.W(6)) u_sync (
      .clk(clk),
      .sys_rst(sys_rst),
      .d({scl_in, sda_in, chip_select_pin_2, chip_select_pin_1,
          chip_select_pin_0, write_protect_input}),
      .q({scl_s, sda_s, cs_s, wp_s})
   );

   bus_cond_detect u_cond (
      .clk(clk),
      .sys_rst(sys_rst),
      .scl_s(scl_s),
      .sda_s(sda_s),
      .scl_rise(scl_rise),
      .scl_fall(scl_fall),
      .start_cond(start_cond),
      .stop_cond(stop_cond)
   );

   // select byte decode; pad pull-downs make floating pins read as zero
   wire [3:0] sel_type = shift_ff[`SEL_TYPE_HI:`SEL_TYPE_LO]; // R1
   wire [2:0] sel_cs = shift_ff[`SEL_CS_HI:`SEL_CS_LO];
   wire cs_match = (sel_cs == cs_s); // R3 R4
   wire is_array = (sel_type == `TYPE_ARRAY); // R1
   wire is_idpage = (HAS_ID_PAGE != 0) && (sel_type == `TYPE_IDPAGE); // R2
   wire sel_hit = cs_match & (is_array | is_idpage); // R23
   wire sel_read = (shift_ff[`SEL_RW_BIT] == `DIR_READ);
   wire byte_done = (bit_cnt_ff == `BITS_PER_BYTE);

   // byte seen by the read path at the current address
   wire [MEM_AW-1:0] mem_idx = addr_ff[MEM_AW-1:0]; // R13
   wire [PAGE_AW-1:0] col_idx = addr_ff[PAGE_AW-1:0];
   wire [7:0] rd_byte = id_sel_ff ? id_mem[col_idx] : mem[mem_idx];

   // page commit walks the whole column range, one column per clock
   wire [MEM_AW-1:0] commit_idx = {addr_ff[MEM_AW-1:PAGE_AW], commit_col_ff};
   wire commit_last = (commit_col_ff == {PAGE_AW{1'b1}});

   // only a pull to ground is ever driven; high comes from the pull-up
   assign sda_out = 1'b0; // R18
   assign sda_oe_n = ~pull_low_ff; // R18
   assign standby = (state_ff == ST_IDLE); // R15 R17
   assign write_busy = (state_ff == ST_WCYC);

   // protocol engine; every bit step follows an scl edge of the master
   always @(posedge clk) begin
      if (sys_rst) begin
         state_ff <= ST_IDLE; // R14 R15 R16
         bit_cnt_ff <= 4'h0;
         shift_ff <= `SHIFT_RESET;
         ack_slot_ff <= 1'b0;
         pull_low_ff <= 1'b0;
         id_sel_ff <= 1'b0;
         wp_hold_ff <= 1'b0;
         data_acked_ff <= 1'b0;
         master_nack_ff <= 1'b0;
         addr_ff <= `ADDR_RESET;
         commit_col_ff <= {PAGE_AW{1'b0}};
         page_vld_ff <= {PAGE{1'b0}};
      end else if (state_ff == ST_WCYC) begin
         // the bus is ignored while the page is being committed
         pull_low_ff <= 1'b0;
         if (page_vld_ff[commit_col_ff] && !id_sel_ff) begin
            mem[commit_idx] <= page_buf[commit_col_ff];
         end
         if (page_vld_ff[commit_col_ff] && id_sel_ff) begin
            id_mem[commit_col_ff] <= page_buf[commit_col_ff];
         end
         commit_col_ff <= commit_col_ff + {{(PAGE_AW-1){1'b0}}, 1'b1};
         if (commit_last) begin
            page_vld_ff <= {PAGE{1'b0}};
            state_ff <= ST_IDLE;
         end
      end else if (start_cond) begin
         // a start, repeated or not, opens a fresh select byte unless a write cycle runs
         state_ff <= ST_SEL; // R11
         bit_cnt_ff <= 4'h0;
         ack_slot_ff <= 1'b0;
         pull_low_ff <= 1'b0;
         data_acked_ff <= 1'b0;
         wp_hold_ff <= wp_s; // R7
         page_vld_ff <= {PAGE{1'b0}};
      end else if (stop_cond) begin
         pull_low_ff <= 1'b0;
         ack_slot_ff <= 1'b0;
         bit_cnt_ff <= 4'h0;
         // commit only if the stop sits right after a data acknowledge; the
         // clock of the tenth slot has already risen once, so one bit is counted
         if (state_ff == ST_WDAT && data_acked_ff && bit_cnt_ff == 4'h1 &&
             page_vld_ff != {PAGE{1'b0}}) begin
            state_ff <= ST_WCYC; // R24
            commit_col_ff <= {PAGE_AW{1'b0}};
         end else begin
            state_ff <= ST_IDLE; // R17 R10
         end
      end else if (state_ff != ST_IDLE && scl_rise) begin
         if (ack_slot_ff) begin
            // in a read the master answers in the ninth period
            master_nack_ff <= sda_s; // R9
         end else if (state_ff != ST_RDAT) begin
            shift_ff <= {shift_ff[6:0], sda_s}; // R26 R19
            bit_cnt_ff <= bit_cnt_ff + 4'h1;
            // keep the acknowledge mark over the first pulse, where a stop may come
            if (bit_cnt_ff != 4'h0) begin
               data_acked_ff <= 1'b0; // R24
            end
            if (state_ff == ST_SEL || state_ff == ST_AHI ||
                state_ff == ST_ALO) begin
               // protect level is held from start to the last address bit
               wp_hold_ff <= wp_hold_ff | wp_s; // R7
            end
         end else begin
            bit_cnt_ff <= bit_cnt_ff + 4'h1;
         end
      end else if (state_ff != ST_IDLE && scl_fall) begin
         if (!ack_slot_ff && byte_done) begin
            // ninth period opens: decide on our acknowledge
            ack_slot_ff <= 1'b1;
            pull_low_ff <= 1'b0;
            case (state_ff)
               ST_SEL: begin
                  if (sel_hit) begin
                     pull_low_ff <= 1'b1; // R12
                     id_sel_ff <= is_idpage;
                  end else begin
                     state_ff <= ST_IDLE; // R23
                     ack_slot_ff <= 1'b0;
                  end
               end
               ST_AHI: begin
                  addr_ff[15:8] <= shift_ff; // R20 R25
                  pull_low_ff <= 1'b1; // R7 R8
               end
               ST_ALO: begin
                  addr_ff[7:0] <= shift_ff; // R21
                  pull_low_ff <= 1'b1; // R7 R8
               end
               ST_WDAT: begin
                  // protect held from start to the last address bit, or high here, blocks the byte; a pad
                  // pull-down keeps an open protect pin low, so writes go on
                  if (!wp_hold_ff && !wp_s) begin // R5 R6 R7
                     // roll-over wraps inside the row
                     page_buf[col_idx] <= shift_ff;
                     page_vld_ff[col_idx] <= 1'b1;
                     addr_ff[PAGE_AW-1:0] <= col_idx +
                        {{(PAGE_AW-1){1'b0}}, 1'b1};
                     pull_low_ff <= 1'b1; // R8
                  end
                  // with protect high the data byte gets no acknowledge
               end
               ST_RDAT: begin
                  pull_low_ff <= 1'b0;
               end
               default: begin
                  state_ff <= ST_IDLE;
               end
            endcase
         end else if (ack_slot_ff) begin
            // ninth period closes
            ack_slot_ff <= 1'b0;
            bit_cnt_ff <= 4'h0;
            pull_low_ff <= 1'b0;
            case (state_ff)
               ST_SEL: begin
                  if (sel_read) begin
                     state_ff <= ST_RDAT;
                     shift_ff <= rd_byte;
                     pull_low_ff <= ~rd_byte[7]; // R26
                  end else begin
                     state_ff <= ST_AHI;
                  end
               end
               ST_AHI: begin
                  state_ff <= ST_ALO;
               end
               ST_ALO: begin
                  state_ff <= ST_WDAT;
               end
               ST_WDAT: begin
                  // a stop may follow now and start the write cycle, but only
                  // after a byte that we acknowledged, never after a refused one
                  data_acked_ff <= pull_low_ff; // R24
               end
               ST_RDAT: begin
                  if (master_nack_ff) begin
                     // master is done; wait released for its stop
                     state_ff <= ST_IDLE; // R10
                  end else begin
                     addr_ff <= addr_ff + 16'h0001;
                     shift_ff <= id_sel_ff ?
                        id_mem[col_idx + {{(PAGE_AW-1){1'b0}}, 1'b1}] :
                        mem[mem_idx + {{(MEM_AW-1){1'b0}}, 1'b1}];
                     pull_low_ff <= id_sel_ff ?
                        ~id_mem[col_idx + {{(PAGE_AW-1){1'b0}}, 1'b1}][7] :
                        ~mem[mem_idx + {{(MEM_AW-1){1'b0}}, 1'b1}][7];
                  end
               end
               default: begin
                  state_ff <= ST_IDLE;
               end
            endcase
         end else if (state_ff == ST_RDAT) begin
            // present the next bit while the clock is low
            shift_ff <= {shift_ff[6:0], 1'b0}; // R26
            if (bit_cnt_ff < `BITS_PER_BYTE) begin
               pull_low_ff <= ~shift_ff[6]; // R18
            end
         end
      end
   end
endmodule

// [sync2.v]
/*
 two flip-flop synchroniser for a group of level inputs.
 assumes the inputs come from outside the clk domain; the first stage is
 read by the second stage only.
*/
`timescale 1ns/1ps
module sync2 #(
   parameter W = 1
) (
   input wire clk,
   input wire sys_rst,
   input wire [W-1:0] d,
   output wire [W-1:0] q
);
   reg [W-1:0] meta_ff;
   reg [W-1:0] stable_ff;

   // both stages clear to zero under reset
   always @(posedge clk) begin
      if (sys_rst) begin
         meta_ff <= {W{1'b0}};
         stable_ff <= {W{1'b0}};
      end else begin
         meta_ff <= d;
         stable_ff <= meta_ff;
      end
   end

   assign q = stable_ff;
endmodule

// [tb_eeprom_slave_front_end.sv]
/*
 self-checking bench for the two-wire eeprom front end.
 assumes the master model and the checker are compiled first.
*/
`timescale 1ns/1ps
module tb_eeprom_slave_front_end;
   logic clk;
   logic sys_rst;
   logic [2:0] cs_pins;
   logic wp;
   wire scl;
   wire m_sda;
   wire sda_out;
   wire sda_oe_n;
   wire standby;
   wire write_busy;
   wire sda_line;
   int error_cnt;
   int total_checks;
   // pull-up: the line is low when either party pulls it
   assign sda_line = m_sda & (sda_oe_n | sda_out);
   eeprom_slave_front_end dut (.clk(clk), .sys_rst(sys_rst), .scl_in(scl), .sda_in(sda_line),
      .sda_out(sda_out), .sda_oe_n(sda_oe_n), .chip_select_pin_0(cs_pins[0]),
      .chip_select_pin_1(cs_pins[1]), .chip_select_pin_2(cs_pins[2]),
      .write_protect_input(wp), .standby(standby), .write_busy(write_busy));
   twi_master_model m (.clk(clk), .sda_line(sda_line), .scl(scl), .sda_drv(m_sda));
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   task chk(input logic [7:0] got, input logic [7:0] exp);
      begin
         total_checks++;
         if (got !== exp) begin
            error_cnt++;
            $display("FAIL %0t: got %h expected %h", $time, got, exp);
         end
      end
   endtask
   task wb(input logic [7:0] b, input logic exp);
      logic a;
      begin
         m.wr_byte(b, a);
         chk({7'h00, a}, {7'h00, exp});
      end
   endtask
   task addr(input logic [3:0] kind, input logic [15:0] a);
      begin
         m.start;
         wb({kind, cs_pins, 1'b0}, 1'b1);
         wb(a[15:8], 1'b1);
         wb(a[7:0], 1'b1);
      end
   endtask
   // random read of one byte, closed by not_acknowledge and stop
   task rd_at(input logic [3:0] kind, input logic [15:0] a, input logic [7:0] exp);
      logic [7:0] d;
      begin
         addr(kind, a);
         m.start;
         wb({kind, cs_pins, 1'b1}, 1'b1);
         m.rd_byte(1'b1, d);
         chk(d, exp);
         m.stop;
      end
   endtask
   task status(input logic [1:0] exp);
      begin
         repeat (10) @(negedge clk);
         chk({6'h00, standby, write_busy}, {6'h00, exp});
      end
   endtask
   task end_sim;
      begin
         $display("checks %0d mismatches %0d", total_checks, error_cnt);
         if (error_cnt == 0 && total_checks > 0)
            $display("No errors found");
         else
            $display("Errors were found");
         $finish;
      end
   endtask
   initial begin
      #200000;
      error_cnt++;
      $display("FAIL %0t: timeout", $time);
      end_sim;
   end
   initial begin
      sys_rst = 1'b1;
      cs_pins = 3'h5;
      wp = 1'b0;
      error_cnt = 0;
      total_checks = 0;
      repeat (4) @(negedge clk);
      sys_rst = 1'b0;
      status(2'h2);
      // all eight chip select codes; stop after the select starts no write
      for (int k = 0; k < 8; k++) begin
         m.start;
         wb({4'ha, k[2:0], 1'b0}, k == 5);
         m.stop;
         status(2'h2);
      end
      // grounded chip selects answer to code zero
      cs_pins = 3'h0;
      m.start;
      wb({4'ha, 3'h0, 1'b0}, 1'b1);
      m.stop;
      cs_pins = 3'h5;
      // an unknown type field is never acknowledged
      m.start;
      wb({4'h5, cs_pins, 1'b0}, 1'b0);
      m.stop;
      status(2'h2);
      $display("test select done");
      addr(4'ha, 16'h1234);
      wb(8'h5a, 1'b1);
      wb(8'hc3, 1'b1);
      m.stop;
      status(2'h1);
      m.start;
      wb({4'ha, cs_pins, 1'b0}, 1'b0);
      m.stop;
      status(2'h2);
      addr(4'ha, 16'h1234);
      m.start;
      wb({4'ha, cs_pins, 1'b1}, 1'b1);
      rd_check: begin
         logic [7:0] d;
         m.rd_byte(1'b0, d);
         chk(d, 8'h5a);
         m.rd_byte(1'b1, d);
         chk(d, 8'hc3);
      end
      m.stop;
      status(2'h2);
      $display("test write read done");
      wp = 1'b1;
      addr(4'ha, 16'h1234);
      wb(8'hff, 1'b0);
      m.stop;
      status(2'h2);
      wp = 1'b0;
      rd_at(4'ha, 16'h1234, 8'h5a);
      $display("test protect done");
      addr(4'hb, 16'h0003);
      wb(8'h77, 1'b1);
      m.stop;
      status(2'h1);
      repeat (150) @(negedge clk);
      rd_at(4'hb, 16'h0003, 8'h77);
      $display("test id page done");
      addr(4'ha, 16'h0040);
      wb(8'h11, 1'b1);
      m.stop;
      sys_rst = 1'b1;
      m.start;
      wb({4'ha, cs_pins, 1'b0}, 1'b0);
      m.stop;
      sys_rst = 1'b0;
      status(2'h2);
      m.start;
      wb({4'ha, cs_pins, 1'b0}, 1'b1);
      m.stop;
      status(2'h2);
      $display("test reset done");
      end_sim;
   end
endmodule

// [twi_master_model.sv]
/*
 two-wire bus master model that opens, clocks and closes every frame.
 assumes the bench resolves the data line with a pull-up.
*/
`timescale 1ns/1ps
module twi_master_model (
   input wire clk,
   input wire sda_line,
   output logic scl,
   output logic sda_drv
);
   // idle bus: clock stands high between frames, data released
   initial begin
      scl = 1'b1;
      sda_drv = 1'b1;
   end
   // data moves 3 clocks after the clock edge, so no false start or stop
   task ph(input logic s, input logic d);
      begin
         scl = s;
         repeat (3) @(negedge clk);
         sda_drv = d;
         repeat (7) @(negedge clk);
      end
   endtask
   task start;
      begin
         ph(1'b0, 1'b1);
         ph(1'b1, 1'b1);
         ph(1'b1, 1'b0);
         ph(1'b0, 1'b0);
      end
   endtask
   task stop;
      begin
         ph(1'b0, 1'b0);
         ph(1'b1, 1'b0);
         ph(1'b1, 1'b1);
      end
   endtask
   // one bit of 160 ns, the line sampled in the middle of clock high
   task bit_io(input logic b, output logic r);
      begin
         ph(1'b0, b);
         ph(1'b0, b);
         ph(1'b1, b);
         r = sda_line;
         ph(1'b1, b);
      end
   endtask
   task wr_byte(input logic [7:0] d, output logic ack);
      logic r;
      begin
         for (int i = 7; i >= 0; i--) bit_io(d[i], r);
         bit_io(1'b1, r);
         ack = ~r;
      end
   endtask
   task rd_byte(input logic last, output logic [7:0] d);
      logic r;
      begin
         for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
         bit_io(last, r);
      end
   endtask
endmodule
